/* File: core/port_ingress_defines.svh */
`ifndef PORT_INGRESS_DEFINES_SVH
`define PORT_INGRESS_DEFINES_SVH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define ADDR_ACL_CMD   8'h00
`define ADDR_BE_MSB    8'h04
`define ADDR_BE_LSB    8'h08
`define ADDR_MIRROR    8'h0C
`define ADDR_PRIO      8'h10
`define ADDR_DEFPRIO   8'h14

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CMD_WDONE      6
`define CMD_RDONE      5
`define CMD_DIR        4
`define MIR_RX         6
`define MIR_TX         5
`define MIR_SNIF       1
`define PRI_HIGH       7
`define PRI_OR         6

// ----------------------------------------------------------------------------
// writable and readable masks and reset values
// ----------------------------------------------------------------------------
`define CMD_WMASK      8'h1F
`define CMD_RMASK      8'h7F
`define MIR_MASK       8'h62
`define PRI_MASK       8'hDF
`define DEF_MASK       8'h07
`define RST_BYTE       8'h00
`define RST_WORD       32'h0000_0000
`define RST_PRIO       3'h0

`endif

/* File: core/port_ingress_pkg.sv */
package port_ingress_pkg;

  // ----------------------------------------------------------------------------
  // entry access sequencer
  // ----------------------------------------------------------------------------
  typedef enum logic {
    ACC_IDLE,
    ACC_BUSY
  } acc_state_t;

endpackage

/* File: core/port_ingress_ctrl_regs.sv */
// Operation
// - write done bit, clears on write launch, resets 1
// - read done bit, clears on read launch, resets 1
// - low byte enable write launches indexed access when sequencer is idle
// - receive sniff marks received packets monitored
// - transmit sniff marks sent packets monitored
// - sniffer bit makes port the sniffer
// - highest select takes maximum enabled result
// - combine select ORs all enabled results when highest select is clear
// - MAC classification follows its enable bit
// - VLAN classification follows its enable bit
// - 802.1p classification follows its enable bit
// - DiffServ classification follows its enable bit
// - ACL classification enable; control bits reset 0
// - no classification gives default priority
`timescale 1ns/1ps
`default_nettype none
`include "port_ingress_defines.svh"

module port_ingress_ctrl_regs
  import port_ingress_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock, reset, enable
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // entry access engine
  output logic                   acl_req,
  output logic                   acl_dir,
  output logic      [3:0]        list_entry_index,
  output logic      [15:0]       acl_be,
  input  wire logic              acl_done,
  // mirroring
  input  wire logic              rx_pkt_start,
  input  wire logic              tx_pkt_start,
  output logic                   rx_monitor,
  output logic                   tx_monitor,
  output logic                   sniffer_port,
  // classification results, bit order acl, dscp, dot1p, vlan, mac
  input  wire logic              ing_valid,
  input  wire logic [4:0]        cls_hit,
  input  wire logic [2:0]        acl_cls_prio,
  input  wire logic [2:0]        dscp_cls_prio,
  input  wire logic [2:0]        dot1p_cls_prio,
  input  wire logic [2:0]        vlan_cls_prio,
  input  wire logic [2:0]        mac_cls_prio,
  output logic                   prio_valid,
  output logic      [2:0]        ing_prio
);

  // ----------------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------------
  logic       setup;
  logic       wr_en;
  logic       mapped;
  logic       launch;
  logic       wr_done;
  logic       rd_done;
  logic [7:0] cmd;
  logic [7:0] be_msb;
  logic [7:0] be_lsb;
  logic [7:0] mirror_ctrl;
  logic [7:0] prio_ctrl;
  logic [7:0] def_prio;
  logic [7:0] next_rdata;
  acc_state_t state;

  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pready & pwrite & pstrb[0];
  assign mapped = (paddr == `ADDR_ACL_CMD) || (paddr == `ADDR_BE_MSB) || (paddr == `ADDR_BE_LSB) ||
                  (paddr == `ADDR_MIRROR) || (paddr == `ADDR_PRIO) || (paddr == `ADDR_DEFPRIO);
  assign launch = wr_en & (paddr == `ADDR_BE_LSB) & (state == ACC_IDLE);

  always_comb begin
    next_rdata = `RST_BYTE;
    case (paddr)
      `ADDR_ACL_CMD: next_rdata = {1'b0, wr_done, rd_done, cmd[4:0]};
      `ADDR_BE_MSB:  next_rdata = be_msb;
      `ADDR_BE_LSB:  next_rdata = be_lsb;
      `ADDR_MIRROR:  next_rdata = mirror_ctrl & `MIR_MASK;
      `ADDR_PRIO:    next_rdata = prio_ctrl & `PRI_MASK;
      `ADDR_DEFPRIO: next_rdata = def_prio & `DEF_MASK;
      default:       next_rdata = `RST_BYTE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `RST_WORD;
    end else if (ce) begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= {24'h00_0000, next_rdata};
      end
    end
  end

  // ----------------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd         <= `RST_BYTE;
      be_msb      <= `RST_BYTE;
      be_lsb      <= `RST_BYTE;
      mirror_ctrl <= `RST_BYTE;
      prio_ctrl   <= `RST_BYTE;
      def_prio    <= `RST_BYTE;
    end else if (ce && wr_en) begin
      case (paddr)
        `ADDR_ACL_CMD: cmd         <= pwdata[7:0] & `CMD_WMASK;
        `ADDR_BE_MSB:  be_msb      <= pwdata[7:0];
        `ADDR_BE_LSB:  be_lsb      <= pwdata[7:0];
        `ADDR_MIRROR:  mirror_ctrl <= pwdata[7:0] & `MIR_MASK;
        `ADDR_PRIO:    prio_ctrl   <= pwdata[7:0] & `PRI_MASK;
        `ADDR_DEFPRIO: def_prio    <= pwdata[7:0] & `DEF_MASK;
        default:       cmd         <= cmd;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // entry access sequencer
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state            <= ACC_IDLE;
      wr_done          <= 1'b1;
      rd_done          <= 1'b1;
      acl_req          <= 1'b0;
      acl_dir          <= 1'b0;
      list_entry_index <= 4'h0;
      acl_be           <= 16'h0000;
    end else if (ce) begin
      acl_req <= launch;
      case (state)
        ACC_IDLE: begin
          if (launch) begin
            state            <= ACC_BUSY;
            acl_dir          <= cmd[`CMD_DIR];
            list_entry_index <= cmd[3:0];
            acl_be           <= {be_msb, pwdata[7:0]};
            if (cmd[`CMD_DIR]) begin
              wr_done <= 1'b0;
            end else begin
              rd_done <= 1'b0;
            end
          end
        end
        ACC_BUSY: begin
          if (acl_done) begin
            state   <= ACC_IDLE;
            wr_done <= 1'b1;
            rd_done <= 1'b1;
          end
        end
        default: state <= ACC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // mirroring
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_monitor   <= 1'b0;
      tx_monitor   <= 1'b0;
      sniffer_port <= 1'b0;
    end else if (ce) begin
      rx_monitor   <= rx_pkt_start & mirror_ctrl[`MIR_RX];
      tx_monitor   <= tx_pkt_start & mirror_ctrl[`MIR_TX];
      sniffer_port <= mirror_ctrl[`MIR_SNIF];
    end
  end

  // ----------------------------------------------------------------------------
  // priority resolution
  // ----------------------------------------------------------------------------
  logic [2:0] src_prio [5];
  logic [4:0] en_hit;
  logic [2:0] pr_max;
  logic [2:0] pr_or;
  logic [2:0] pr_first;
  logic [2:0] next_prio;

  assign src_prio[0] = acl_cls_prio;
  assign src_prio[1] = dscp_cls_prio;
  assign src_prio[2] = dot1p_cls_prio;
  assign src_prio[3] = vlan_cls_prio;
  assign src_prio[4] = mac_cls_prio;
  assign en_hit      = cls_hit & prio_ctrl[4:0];

  always_comb begin
    pr_max   = `RST_PRIO;
    pr_or    = `RST_PRIO;
    pr_first = `RST_PRIO;
    for (int i = 0; i < 5; i++) begin
      if (en_hit[i]) begin
        pr_or    = pr_or | src_prio[i];
        pr_first = src_prio[i];
        if (src_prio[i] > pr_max) begin
          pr_max = src_prio[i];
        end
      end
    end
    if (en_hit == 5'h00) begin
      next_prio = def_prio[2:0];
    end else if (prio_ctrl[`PRI_HIGH]) begin
      next_prio = pr_max;
    end else if (prio_ctrl[`PRI_OR]) begin
      next_prio = pr_or;
    end else begin
      next_prio = pr_first;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_valid <= 1'b0;
      ing_prio   <= `RST_PRIO;
    end else if (ce) begin
      prio_valid <= ing_valid;
      if (ing_valid) begin
        ing_prio <= next_prio;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  sequence launch_wr_s;
    launch && cmd[`CMD_DIR];
  endsequence
  sequence launch_rd_s;
    launch && !cmd[`CMD_DIR];
  endsequence

  wr_busy_a: assert property (launch_wr_s |=> !wr_done && acl_req && acl_dir)
    else $error("write done not cleared on write launch");
  rd_busy_a: assert property (launch_rd_s |=> !rd_done && wr_done && !acl_dir)
    else $error("read done not cleared on read launch");
  done_sets_a: assert property ((state == ACC_BUSY) && acl_done |=> wr_done && rd_done && state == ACC_IDLE)
    else $error("done bits not set on completion");
  launch_be_a: assert property (launch |=> acl_be == {$past(be_msb), $past(pwdata[7:0])})
    else $error("byte enables not captured at launch");
  rx_mon_a: assert property (rx_pkt_start |=> rx_monitor == $past(mirror_ctrl[`MIR_RX]))
    else $error("receive monitor mismatch");
  tx_mon_a: assert property (tx_pkt_start |=> tx_monitor == $past(mirror_ctrl[`MIR_TX]))
    else $error("transmit monitor mismatch");
  sniff_set_a: assert property (wr_en && paddr == `ADDR_MIRROR && pwdata[`MIR_SNIF] |=> ##1 sniffer_port)
    else $error("sniffer port not set");
  def_prio_a: assert property (ing_valid && en_hit == 5'h00 |=> prio_valid && ing_prio == $past(def_prio[2:0]))
    else $error("default priority not applied");
  high_prio_a: assert property (ing_valid && en_hit != 5'h00 && prio_ctrl[`PRI_HIGH] |=> ing_prio >= $past(pr_first))
    else $error("highest priority below a result");
  or_prio_a: assert property (ing_valid && en_hit != 5'h00 && !prio_ctrl[`PRI_HIGH] && prio_ctrl[`PRI_OR]
                              |=> (ing_prio & $past(pr_first)) == $past(pr_first))
    else $error("combined priority misses a result");
  rsvd_zero_a: assert property (setup && paddr == `ADDR_MIRROR |=> (prdata & ~{24'h00_0000, `MIR_MASK}) == `RST_WORD)
    else $error("reserved bits read nonzero");
  cmd_rsvd_a: assert property (setup && paddr == `ADDR_ACL_CMD
                               |=> (prdata & ~{24'h00_0000, `CMD_RMASK}) == `RST_WORD)
    else $error("command reserved bit reads nonzero");
  acl_pulse_a: assert property (acl_req |=> !acl_req)
    else $error("access request longer than one cycle");
  sniff_follow_a: assert property (1'b1 |=> sniffer_port == $past(mirror_ctrl[`MIR_SNIF]))
    else $error("sniffer port does not follow its bit");
  err_resp_a: assert property (setup && !mapped |=> pready && pslverr && prdata == `RST_WORD)
    else $error("unmapped access not refused");

  ce_freeze_a: assert property (disable iff (!presetn) !ce |=> $stable(state) && $stable(ing_prio)
                                && $stable(mirror_ctrl) && $stable(prio_valid))
    else $error("state moved while clock enable low");

endmodule

`default_nettype wire

/* File: verif/port_ingress_ctrl_regs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "port_ingress_defines.svh"

module port_ingress_ctrl_regs_tb_top
  import port_ingress_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0]  pstrb, list_entry_index;
  logic        acl_req, acl_dir, acl_done, rx_pkt_start, tx_pkt_start, ce;
  logic        rx_monitor, tx_monitor, sniffer_port, ing_valid, prio_valid;
  logic [15:0] acl_be;
  logic [4:0]  cls_hit;
  logic [2:0]  ing_prio;
  int          n_mismatch, n_compared;

  port_ingress_ctrl_regs port_ingress_ctrl_regs_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .acl_req(acl_req), .acl_dir(acl_dir), .list_entry_index(list_entry_index), .acl_be(acl_be),
    .acl_done(acl_done), .rx_pkt_start(rx_pkt_start), .tx_pkt_start(tx_pkt_start),
    .rx_monitor(rx_monitor), .tx_monitor(tx_monitor), .sniffer_port(sniffer_port),
    .ing_valid(ing_valid), .cls_hit(cls_hit), .acl_cls_prio(3'h1), .dscp_cls_prio(3'h2),
    .dot1p_cls_prio(3'h4), .vlan_cls_prio(3'h3), .mac_cls_prio(3'h6), .prio_valid(prio_valid),
    .ing_prio(ing_prio));

  always #2.5 pclk = ~pclk;

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------------------
  // apb master
  // ----------------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdata, e);
  endtask

  task automatic pulse_done();
    @(posedge pclk);
    acl_done <= 1'b1;
    @(posedge pclk);
    acl_done <= 1'b0;
  endtask

  task automatic mir(input logic [7:0] c, input logic erx, input logic etx);
    apb(1'b1, `ADDR_MIRROR, {24'h00_0000, c});
    @(posedge pclk);
    rx_pkt_start <= 1'b1;
    tx_pkt_start <= 1'b1;
    @(posedge pclk);
    rx_pkt_start <= 1'b0;
    tx_pkt_start <= 1'b0;
    #1;
    chk(32'({rx_monitor, tx_monitor, sniffer_port}), 32'({erx, etx, c[1]}));
  endtask

  task automatic cls(input logic [7:0] c, input logic [4:0] hit, input logic [2:0] e);
    apb(1'b1, `ADDR_PRIO, {24'h00_0000, c});
    @(posedge pclk);
    ing_valid <= 1'b1;
    cls_hit <= hit;
    @(posedge pclk);
    ing_valid <= 1'b0;
    #1;
    chk(32'({prio_valid, ing_prio}), 32'({1'b1, e}));
  endtask

  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, acl_done, rx_pkt_start, tx_pkt_start, ing_valid} = '0;
    {paddr, pwdata, cls_hit} = '0;
    pstrb = 4'h1;
    ce = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`ADDR_ACL_CMD, 32'h0000_0060);
    rd_chk(`ADDR_PRIO, 32'h0000_0000);
    rd_chk(`ADDR_MIRROR, 32'h0000_0000);
    apb(1'b1, `ADDR_MIRROR, 32'hFFFF_FFFF);
    rd_chk(`ADDR_MIRROR, 32'h0000_0062);
    apb(1'b1, `ADDR_PRIO, 32'h0000_00FF);
    rd_chk(`ADDR_PRIO, 32'h0000_00DF);
    apb(1'b1, `ADDR_ACL_CMD, 32'h0000_00FF);
    rd_chk(`ADDR_ACL_CMD, 32'h0000_007F);
    apb(1'b1, 8'h3C, 32'h0000_00FF);
    chk({31'h0000_0000, last_err}, 32'h0000_0001);
    $display("test registers done");
    apb(1'b1, `ADDR_ACL_CMD, 32'h0000_0015);
    apb(1'b1, `ADDR_BE_MSB, 32'h0000_00A5);
    apb(1'b1, `ADDR_BE_LSB, 32'h0000_003C);
    #1;
    chk(32'({acl_req, acl_dir, list_entry_index, acl_be}), 32'({1'b1, 1'b1, 4'h5, 16'hA53C}));
    rd_chk(`ADDR_ACL_CMD, 32'h0000_0035);
    pulse_done();
    rd_chk(`ADDR_ACL_CMD, 32'h0000_0075);
    pulse_done();
    rd_chk(`ADDR_ACL_CMD, 32'h0000_0075);
    apb(1'b1, `ADDR_ACL_CMD, 32'h0000_0002);
    apb(1'b1, `ADDR_BE_LSB, 32'h0000_0001);
    #1;
    chk(32'({acl_req, acl_dir, list_entry_index, acl_be}), 32'({1'b1, 1'b0, 4'h2, 16'hA501}));
    rd_chk(`ADDR_ACL_CMD, 32'h0000_0042);
    pulse_done();
    rd_chk(`ADDR_ACL_CMD, 32'h0000_0062);
    $display("test entry access done");
    mir(8'h42, 1'b1, 1'b0);
    mir(8'h20, 1'b0, 1'b1);
    mir(8'h00, 1'b0, 1'b0);
    $display("test mirroring done");
    apb(1'b1, `ADDR_DEFPRIO, 32'h0000_00FD);
    rd_chk(`ADDR_DEFPRIO, 32'h0000_0005);
    pstrb <= 4'h0;
    apb(1'b1, `ADDR_DEFPRIO, 32'h0000_0002);
    pstrb <= 4'h1;
    rd_chk(`ADDR_DEFPRIO, 32'h0000_0005);
    cls(8'h00, 5'h1F, 3'h5);
    cls(8'h10, 5'h1F, 3'h6);
    cls(8'h08, 5'h1F, 3'h3);
    cls(8'h04, 5'h1F, 3'h4);
    cls(8'h02, 5'h1F, 3'h2);
    cls(8'h01, 5'h1F, 3'h1);
    cls(8'h10, 5'h0F, 3'h5);
    cls(8'h9F, 5'h1F, 3'h6);
    cls(8'h87, 5'h07, 3'h4);
    cls(8'h43, 5'h1F, 3'h3);
    cls(8'h4C, 5'h1F, 3'h7);
    @(posedge pclk);
    ce <= 1'b0;
    ing_valid <= 1'b1;
    cls_hit <= 5'h00;
    @(posedge pclk);
    ing_valid <= 1'b0;
    #1;
    chk(32'({prio_valid, ing_prio}), 32'h0000_0007);
    @(posedge pclk);
    ce <= 1'b1;
    $display("test classification done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
